//--- src/sph_regs.svh
// Register offsets, field positions, reset values and timing counts
// Assumes a 32-bit classic Wishbone slave decoding byte addresses [7:0]
`ifndef SPH_REGS_SVH
`define SPH_REGS_SVH
`define SPH_OFS_CTRL 8'h00
`define SPH_OFS_MODE 8'h04
`define SPH_OFS_RX 8'h08
`define SPH_OFS_TX 8'h0C
`define SPH_OFS_STAT 8'h10
`define SPH_OFS_IEN 8'h14
`define SPH_OFS_IDIS 8'h18
`define SPH_OFS_IMSK 8'h1C
`define SPH_OFS_CSCFG 8'h30
`define SPH_CTRL_EN 0
`define SPH_CTRL_DIS 1
`define SPH_CTRL_SWRST 7
`define SPH_MODE_PS 1
`define SPH_MODE_DEC 2
`define SPH_MODE_PCS 16
`define SPH_MODE_MASK 32'h000F0006
`define SPH_TX_PCS 16
`define SPH_TX_CLOSE 24
`define SPH_ST_ENS 16
`define SPH_ST_TXE 9
`define SPH_ST_SELECT_RISE_FLAG 8
`define SPH_ST_OVR 3
`define SPH_ST_MODE_FAULT_FLAG 2
`define SPH_ST_TX_HOLD_EMPTY_FLAG 1
`define SPH_ST_RX_HOLD_FULL_FLAG 0
`define SPH_FLAG_MASK 10'h30F
`define SPH_CS_GAP 24
`define SPH_CS_LEAD 16
`define SPH_CS_BAUD 8
`define SPH_CS_BITS 4
`define SPH_CS_KEEP 3
`define SPH_CS_DROP 2
`define SPH_CS_PHA 1
`define SPH_CS_POL 0
`define SPH_RST_WORD 32'h00000000
`define SPH_CS_IDLE 4'hF
`define SPH_GAP_UNIT 32
`define SPH_BITS_BASE 5'h08
`define SPH_BITS_TOP 4'h8
`endif

//--- src/sph_pkg.sv
// Types shared by the serial host register block
// Assumes sph_regs.svh holds all numeric constants
package sph_pkg;
	typedef enum logic [1:0] {SPH_IDLE, SPH_BUSY, SPH_GAP} sph_st_e;
	typedef struct packed {
		logic ack;
		logic [31:0] rdat;
		logic en;
		logic full;
		logic [15:0] tword;
		logic [3:0] tpcs;
		logic tclose;
		logic [31:0] mode;
		logic [31:0] cscfg;
		logic [9:0] mask;
		logic [15:0] rx;
		logic rx_hold_full_flag;
		logic ovr;
		logic mode_fault_flag;
		logic select_rise_flag;
		logic ss_q;
		sph_st_e st;
		logic [12:0] cnt;
		logic [3:0] cs;
		logic close;
	} sph_state_s;
endpackage : sph_pkg

//--- src/sph_core.sv
// Register, status and select sequencing logic of a serial host port
// Assumes an external shift engine that takes words, shifts them and
// returns received words; all inputs synchronous to clk_i
`timescale 1ns/100ps
`default_nettype none
`include "sph_regs.svh"
module sph_core #(
	parameter int unsigned GAP_UNIT = `SPH_GAP_UNIT
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic xfer_req_o,
	output logic [15:0] xfer_word_o,
	input wire logic xfer_take_i,
	input wire logic xfer_done_i,
	input wire logic rx_load_i,
	input wire logic [15:0] rx_word_i,
	input wire logic mode_fault_i,
	input wire logic slave_select_in_i,
	output logic [3:0] chip_select_out_o,
	output logic [4:0] word_bits_o,
	output logic [7:0] baud_divisor_o,
	output logic [7:0] lead_delay_o,
	output logic clock_phase_sel_o,
	output logic clock_idle_level_o,
	output logic enabled_o,
	output logic irq_o
);
	localparam sph_pkg::sph_state_s RST = '{
		st: sph_pkg::SPH_IDLE,
		cs: `SPH_CS_IDLE,
		ss_q: 1'b1,
		default: '0
	};
	sph_pkg::sph_state_s s;
	sph_pkg::sph_state_s next_s;
	logic acc;
	logic wr;
	logic rd;
	logic [7:0] a;
	logic [31:0] be;
	logic [31:0] wd;
	logic [31:0] sr;
	logic [4:0] nb;
	logic [15:0] wmask;
	logic [3:0] code;
	logic [3:0] pat;
	logic [7:0] gap;
	logic endw;
	logic swrst;
	logic wtx;
	logic rd_rx;
	logic rd_sr;

	assign acc = wb_cyc_i & wb_stb_i & ~s.ack;
	assign wr = acc & wb_we_i;
	assign rd = acc & ~wb_we_i;
	assign a = {wb_adr_i[7:2], 2'b00};
	assign be = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
		{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
	assign wd = wb_dat_i & be;
	assign wtx = wr && a == `SPH_OFS_TX;
	assign rd_rx = rd && a == `SPH_OFS_RX;
	assign rd_sr = rd && a == `SPH_OFS_STAT;
	assign swrst = wr && a == `SPH_OFS_CTRL && wd[`SPH_CTRL_SWRST];
	assign gap = s.cscfg[`SPH_CS_GAP +: 8];

	// Reserved length codes fall back to the longest word
	assign nb = (s.cscfg[`SPH_CS_BITS +: 4] > `SPH_BITS_TOP) ? 5'h10 :
		`SPH_BITS_BASE + {1'b0, s.cscfg[`SPH_CS_BITS +: 4]};
	assign wmask = ~(16'hFFFF << nb);

	// Per-word select code only in variable mode
	assign code = s.mode[`SPH_MODE_PS] ? s.tpcs :
		s.mode[`SPH_MODE_PCS +: 4];
	// Forbidden code 1111 selects nobody
	assign pat = s.mode[`SPH_MODE_DEC] ? code :
		~code[0] ? 4'hE : ~code[1] ? 4'hD :
		~code[2] ? 4'hB : ~code[3] ? 4'h7 : `SPH_CS_IDLE;

	assign sr = {15'h0000, s.en, 6'h00,
		// Gated by enable so the status word resets to zero
		s.en & ~s.full & s.st == sph_pkg::SPH_IDLE,
		s.select_rise_flag, 4'h0, s.ovr, s.mode_fault_flag,
		s.en & ~s.full,
		s.rx_hold_full_flag};

	assign xfer_req_o = s.en & s.full & s.st == sph_pkg::SPH_IDLE;
	assign xfer_word_o = s.tword;
	assign chip_select_out_o = s.cs;
	assign word_bits_o = nb;
	assign baud_divisor_o = s.cscfg[`SPH_CS_BAUD +: 8];
	assign lead_delay_o = s.cscfg[`SPH_CS_LEAD +: 8];
	assign clock_phase_sel_o = s.cscfg[`SPH_CS_PHA];
	assign clock_idle_level_o = s.cscfg[`SPH_CS_POL];
	assign enabled_o = s.en;
	assign irq_o = |(sr[9:0] & s.mask);
	assign wb_dat_o = s.rdat;
	assign wb_ack_o = s.ack;

	always_comb begin
		next_s = s;
		endw = 1'b0;
		next_s.ack = acc;
		next_s.ss_q = slave_select_in_i;
		next_s.rdat = `SPH_RST_WORD;
		if (rd) begin
			case (a)
				`SPH_OFS_MODE: next_s.rdat = s.mode;
				`SPH_OFS_RX: next_s.rdat = {16'h0000, s.rx};
				`SPH_OFS_STAT: next_s.rdat = sr;
				`SPH_OFS_IMSK: next_s.rdat = {22'h000000, s.mask};
				`SPH_OFS_CSCFG: next_s.rdat = s.cscfg;
				default: next_s.rdat = `SPH_RST_WORD;
			endcase
		end
		// Clears first so that a same-cycle event still sets its flag
		if (rd_rx) begin
			next_s.rx_hold_full_flag = 1'b0;
		end
		if (rd_sr) begin
			next_s.ovr = 1'b0;
			next_s.mode_fault_flag = 1'b0;
			next_s.select_rise_flag = 1'b0;
		end
		if (rx_load_i) begin
			next_s.rx = rx_word_i & wmask;
			next_s.rx_hold_full_flag = 1'b1;
			if (s.rx_hold_full_flag && !rd_rx) begin
				next_s.ovr = 1'b1;
			end
		end
		if (mode_fault_i) begin
			next_s.mode_fault_flag = 1'b1;
		end
		if (slave_select_in_i && !s.ss_q) begin
			next_s.select_rise_flag = 1'b1;
		end
		case (s.st)
			sph_pkg::SPH_IDLE: begin
				if (xfer_req_o && xfer_take_i) begin
					next_s.full = 1'b0;
					next_s.st = sph_pkg::SPH_BUSY;
					// A different select simply replaces the held one
					next_s.cs = pat;
					next_s.close = s.mode[`SPH_MODE_PS] & s.tclose;
				end
			end
			sph_pkg::SPH_BUSY: begin
				if (xfer_done_i) begin
					if (gap != 8'h00) begin
						next_s.st = sph_pkg::SPH_GAP;
						next_s.cnt = 13'(32'(gap) * GAP_UNIT);
					end else begin
						endw = 1'b1;
					end
				end
			end
			sph_pkg::SPH_GAP: begin
				if (s.cnt == 13'h0001) begin
					endw = 1'b1;
				end else begin
					next_s.cnt = s.cnt - 13'h0001;
				end
			end
			default: next_s.st = sph_pkg::SPH_IDLE;
		endcase
		if (wr) begin
			case (a)
				`SPH_OFS_CTRL: begin
					if (wd[`SPH_CTRL_EN]) begin
						next_s.en = 1'b1;
					end
					// Disable wins; a pending word is dropped
					if (wd[`SPH_CTRL_DIS]) begin
						next_s.en = 1'b0;
						next_s.full = 1'b0;
					end
				end
				`SPH_OFS_MODE: begin
					next_s.mode = ((s.mode & ~be) | wd) & `SPH_MODE_MASK;
				end
				`SPH_OFS_TX: begin
					next_s.tword = wd[15:0];
					next_s.tpcs = wd[`SPH_TX_PCS +: 4];
					next_s.tclose = wd[`SPH_TX_CLOSE];
					next_s.full = 1'b1;
				end
				`SPH_OFS_IEN: begin
					next_s.mask = s.mask | (wd[9:0] & `SPH_FLAG_MASK);
				end
				`SPH_OFS_IDIS: begin
					next_s.mask = s.mask & ~(wd[9:0] & `SPH_FLAG_MASK);
				end
				`SPH_OFS_CSCFG: begin
					next_s.cscfg = (s.cscfg & ~be) | wd;
				end
				default: next_s.en = next_s.en;
			endcase
		end
		// Select drops only after the gap, never mid-gap
		if (endw) begin
			next_s.st = sph_pkg::SPH_IDLE;
			if (s.close || s.cscfg[`SPH_CS_DROP] ||
				(!s.cscfg[`SPH_CS_KEEP] && !next_s.full)) begin
				next_s.cs = `SPH_CS_IDLE;
			end
		end
		if (swrst) begin
			next_s = RST;
			next_s.ack = 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s <= RST;
		end else begin
			s <= next_s;
		end
	end

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	rx_justify_a: assert property ((rx_load_i && !swrst) |=>
		(s.rx == ($past(rx_word_i) & $past(wmask))))
		else $error("receive word not masked to length");
	close_drop_a: assert property ((s.st == sph_pkg::SPH_BUSY &&
		xfer_done_i && s.close && gap == 8'h00 && !swrst) |=>
		(chip_select_out_o == `SPH_CS_IDLE))
		else $error("select kept after closing word");
	cs_pattern_a: assert property ((xfer_req_o && xfer_take_i &&
		!swrst) |=> (chip_select_out_o == $past(pat)))
		else $error("select pattern wrong");
	ens_clear_a: assert property ((wr && a == `SPH_OFS_CTRL &&
		wd[`SPH_CTRL_DIS]) |=> !sr[`SPH_ST_ENS])
		else $error("enable status stuck");
	txe_clear_a: assert property ((wtx && !swrst) |=>
		!sr[`SPH_ST_TXE] ##1 !sr[`SPH_ST_TXE])
		else $error("all idle not cleared by write");
	select_rise_flag_set_a: assert property ((slave_select_in_i && !s.ss_q &&
		!swrst) |=> sr[`SPH_ST_SELECT_RISE_FLAG])
		else $error("select rise missed");
	ovr_set_a: assert property ((rx_load_i && s.rx_hold_full_flag && !rd_rx &&
		!swrst) |=> s.ovr)
		else $error("overrun missed");
	mode_fault_flag_hold_a: assert property ((s.mode_fault_flag && !rd_sr && !swrst) |=>
		s.mode_fault_flag)
		else $error("mode fault lost before read");
	tx_hold_empty_flag_set_a: assert property ((xfer_req_o && xfer_take_i &&
		!wr) |=> sr[`SPH_ST_TX_HOLD_EMPTY_FLAG])
		else $error("hold empty not set on move");
	rx_hold_full_flag_clear_a: assert property ((rd_rx && !rx_load_i &&
		!swrst) |=> !s.rx_hold_full_flag)
		else $error("receive full not cleared");
	mask_set_a: assert property ((wr && a == `SPH_OFS_IEN &&
		!swrst) |=> ((s.mask & $past(wd[9:0])) ==
		($past(wd[9:0]) & `SPH_FLAG_MASK)))
		else $error("mask bits not set");
	mask_clr_a: assert property ((wr && a == `SPH_OFS_IDIS &&
		!swrst) |=> ((s.mask & $past(wd[9:0])) == 10'h000))
		else $error("mask bits not cleared");
	gap_load_a: assert property ((s.st == sph_pkg::SPH_BUSY &&
		xfer_done_i && gap != 8'h00 && !swrst) |=>
		(s.st == sph_pkg::SPH_GAP &&
		s.cnt == 13'(32'($past(gap)) * GAP_UNIT)))
		else $error("gap length wrong");
	gap_none_a: assert property ((s.st == sph_pkg::SPH_BUSY &&
		xfer_done_i && gap == 8'h00 && !swrst) |=>
		(s.st == sph_pkg::SPH_IDLE))
		else $error("gap inserted when zero");

	word_sent_c: cover property (xfer_req_o && xfer_take_i ##[1:40]
		xfer_done_i);
	gap_done_c: cover property (s.st == sph_pkg::SPH_GAP ##1
		s.st == sph_pkg::SPH_IDLE);
	overrun_c: cover property (rx_load_i && s.rx_hold_full_flag);
	irq_c: cover property (irq_o);
endmodule : sph_core
`default_nettype wire

//--- tb/sph_engine_model.sv
// Shift engine stand-in: takes waiting words and loops them back
// Assumes the request handshake of sph_core and one common clock
`timescale 1ns/100ps
`default_nettype none
module sph_engine_model (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic slow_i,
	input wire logic req_i,
	input wire logic [15:0] word_i,
	input wire logic [4:0] bits_i,
	output logic take_o,
	output logic done_o,
	output logic load_o,
	output logic [15:0] rx_o
);
	logic [5:0] cnt;
	logic [15:0] wd;
	always_ff @(posedge clk_i) begin
		take_o <= 1'b0;
		done_o <= 1'b0;
		load_o <= 1'b0;
		// Stale data toggles so it never looks valid outside a load
		rx_o <= ~rx_o;
		if (rst_i) begin
			cnt <= 6'h00;
			rx_o <= 16'h0000;
		end else if (cnt == 6'h00) begin
			if (req_i) begin
				take_o <= 1'b1;
				wd <= word_i;
				cnt <= slow_i ? 6'h14 : 6'h03;
			end
		end else begin
			cnt <= cnt - 6'h01;
			if (cnt == 6'h01) begin
				done_o <= 1'b1;
				load_o <= 1'b1;
				// Junk above the word length; the core must clear it
				rx_o <= wd | ~16'((17'h1 << bits_i) - 17'h1);
			end
		end
	end
endmodule : sph_engine_model
`default_nettype wire

//--- tb/tb_top.sv
// Self-checking bench for the serial host register core
// Assumes sph_core with a short gap unit and the engine stand-in
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	localparam int GU = 2;
	logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
	logic fault = 1'b0, ss = 1'b0, slow = 1'b0, dropped = 1'b0, drop_seen;
	logic ack, req, take, done, load, irq;
	logic [7:0] adr = 8'h00;
	logic [31:0] dat = 32'h0, rdat, q;
	logic [15:0] xword, rxw;
	logic [3:0] cs;
	logic [4:0] bits;
	logic [7:0] baud, lead;
	logic pha, pol, enab;
	int fails = 0, checks = 0, gcnt = 0, ndone = 0, last_gap, k, nd, g;
	logic [7:0] wa [0:6] = '{8'h14, 8'h18, 8'h14, 8'h30, 8'h20, 8'h1C, 8'h00};
	logic [7:0] ra [0:6] = '{8'h1C, 8'h1C, 8'h1C, 8'h30, 8'h20, 8'h1C, 8'h10};
	logic [31:0] wd [0:6] = '{32'h30F, 32'h30B, 32'h0, 32'h808, 32'hFFFFFFFF,
		32'hFF, 32'h1};
	logic [31:0] ex [0:6] = '{32'h30F, 32'h4, 32'h4, 32'h808, 32'h0, 32'h4,
		32'h10202};
	logic [3:0] codes [0:3] = '{4'h0, 4'h1, 4'h3, 4'h7};
	logic [3:0] lines [0:3] = '{4'hE, 4'hD, 4'hB, 4'h7};
	always #4 clk_i = ~clk_i;
	sph_core #(.GAP_UNIT(GU)) dut_u (.clk_i(clk_i), .rst_i(rst_i),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.xfer_req_o(req), .xfer_word_o(xword), .xfer_take_i(take),
		.xfer_done_i(done), .rx_load_i(load), .rx_word_i(rxw),
		.mode_fault_i(fault), .slave_select_in_i(ss), .chip_select_out_o(cs),
		.word_bits_o(bits), .baud_divisor_o(baud), .lead_delay_o(lead),
		.clock_phase_sel_o(pha), .clock_idle_level_o(pol), .enabled_o(enab),
		.irq_o(irq));
	sph_engine_model eng_u (.clk_i(clk_i), .rst_i(rst_i), .slow_i(slow),
		.req_i(req), .word_i(xword), .bits_i(bits), .take_o(take),
		.done_o(done), .load_o(load), .rx_o(rxw));
	// Gap is timed from the end of one word to the take of the next
	always @(posedge clk_i) begin
		gcnt <= done ? 0 : gcnt + 1;
		dropped <= done ? 1'b0 : (dropped | (cs === 4'hF));
		if (take) last_gap <= gcnt;
		if (take) drop_seen <= dropped;
		if (done) ndone <= ndone + 1;
	end
	task automatic chk(input string n, input logic [31:0] s, e);
		checks++;
		if (s !== e) begin
			fails++;
			$display("[ERR] %s exp %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic wb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n = 0;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && n < 60);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		if (n == 60) fails++;
	endtask : wb
	task automatic poll(input int b);
		int n = 0;
		do begin
			wb(1'b0, 8'h10, 32'h0);
			n++;
		end while (q[b] !== 1'b1 && n < 200);
		if (q[b] !== 1'b1) fails++;
	endtask : poll
	task automatic wait_done(input int t);
		int n = 0;
		while (ndone < t && n < 300) begin
			@(posedge clk_i);
			n++;
		end
		if (ndone < t) fails++;
	endtask : wait_done
	task automatic wait_cs;
		int n = 0;
		while (cs === 4'hF && n < 100) begin
			@(posedge clk_i);
			n++;
		end
		if (cs === 4'hF) fails++;
	endtask : wait_cs
	task automatic tally_and_finish;
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : tally_and_finish
	initial begin
		repeat (20000) @(posedge clk_i);
		fails++;
		tally_and_finish();
	end
	initial begin
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		wb(1'b0, 8'h10, 32'h0);
		chk("status", q, 32'h0);
		wb(1'b0, 8'h1C, 32'h0);
		chk("mask", q, 32'h0);
		chk("select", cs, 32'hF);
		for (k = 0; k < 7; k++) begin
			wb(1'b1, wa[k], wd[k]);
			wb(1'b0, ra[k], 32'h0);
			chk("row", q, ex[k]);
		end
		wb(1'b1, 8'h30, 32'h00A51703);
		chk("link cfg", {lead, baud, 6'h00, pha, pol}, 32'hA51703);
		chk("enabled", enab, 32'h1);
		wb(1'b1, 8'h30, 32'h808);
		wb(1'b1, 8'h04, 32'h2);
		for (k = 0; k < 4; k++) begin
			wb(1'b1, 8'h0C, {8'h01, 4'h0, codes[k], 16'h00A5});
			wait_cs();
			chk("line", cs, lines[k]);
			poll(9);
			chk("closed", cs, 32'hF);
		end
		wb(1'b1, 8'h04, 32'h6);
		wb(1'b1, 8'h0C, 32'h010500A5);
		wait_cs();
		chk("decoded", cs, 32'h5);
		poll(9);
		wb(1'b1, 8'h04, 32'h000B0000);
		wb(1'b1, 8'h0C, 32'h010000A5);
		wait_cs();
		chk("fixed", cs, 32'hB);
		poll(9);
		chk("kept", cs, 32'hB);
		wb(1'b0, 8'h10, 32'h0);
		wb(1'b0, 8'h08, 32'h0);
		nd = ndone;
		wb(1'b1, 8'h0C, 32'h1234);
		wait_done(nd + 1);
		wb(1'b1, 8'h0C, 32'h3C5A);
		wait_done(nd + 2);
		wb(1'b0, 8'h10, 32'h0);
		chk("overrun", q, 32'h1020B);
		wb(1'b0, 8'h08, 32'h0);
		chk("rx", q, 32'h5A);
		wb(1'b0, 8'h10, 32'h0);
		chk("cleared", q, 32'h10202);
		// Twelve-bit word with junk above the length, then a sixteen-bit word with none
		wb(1'b1, 8'h30, 32'h848);
		nd = ndone;
		wb(1'b1, 8'h0C, 32'h3C5A);
		wait_done(nd + 1);
		wb(1'b0, 8'h08, 32'h0);
		chk("rx12", q, 32'hC5A);
		wb(1'b1, 8'h30, 32'h888);
		nd = ndone;
		wb(1'b1, 8'h0C, 32'h3C5A);
		wait_done(nd + 1);
		wb(1'b0, 8'h08, 32'h0);
		chk("rx16", q, 32'h3C5A);
		fault <= 1'b1;
		ss <= 1'b1;
		@(posedge clk_i);
		fault <= 1'b0;
		@(posedge clk_i);
		chk("irq", irq, 32'h1);
		wb(1'b0, 8'h10, 32'h0);
		chk("events", q, 32'h10306);
		chk("irq off", irq, 32'h0);
		slow <= 1'b1;
		wb(1'b1, 8'h04, 32'h2);
		for (g = 3; g >= 0; g -= 3) begin
			wb(1'b1, 8'h30, {g[7:0], 24'h000808});
			nd = ndone;
			wb(1'b1, 8'h0C, 32'h11);
			poll(1);
			wb(1'b1, 8'h0C, 32'h22);
			wait_done(nd + 2);
			chk("gap", last_gap >= GU * g && last_gap <= GU * g + 5, 1);
			chk("held", drop_seen, 32'h0);
		end
		wb(1'b1, 8'h00, 32'h2);
		wb(1'b0, 8'h10, 32'h0);
		chk("off", q & 32'h10002, 32'h0);
		chk("enabled off", enab, 32'h0);
		// Software reset overrides an enable in the same write
		wb(1'b1, 8'h14, 32'h30F);
		wb(1'b1, 8'h00, 32'h81);
		wb(1'b0, 8'h1C, 32'h0);
		chk("swrst mask", q, 32'h0);
		wb(1'b0, 8'h10, 32'h0);
		chk("swrst status", q, 32'h0);
		chk("swrst select", cs, 32'hF);
		wb(1'b1, 8'h00, 32'h1);
		rst_i <= 1'b1;
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		wb(1'b0, 8'h10, 32'h0);
		chk("rst status", q, 32'h0);
		chk("rst irq", irq, 32'h0);
		tally_and_finish();
	end
endmodule : tb_top
`default_nettype wire
